// *** hw/mmbs_memory_map.sv ***
// mmbs_memory_map: program counter, program store and banked data file.
// assumes the core drives fetch and data strobes on clk_sys; peripheral
// registers other than status and pointer answer through the ext port.
// Functional notes
// (RL1) program counter is 13 bits, spanning an 8K by 14-bit space.
// (RL2) only 2K words exist; higher fetch addresses wrap onto them.
// (RL3) any reset starts execution at program address zero.
// (RL4) a taken interrupt sends execution to program address four.
// (RL5) fetch and data access use separate buses, concurrently.
// (RL6) status bits 6 and 5 select one of four data banks.
// (RL7) each bank covers offsets 00h to 7Fh, 128 bytes.
// (RL8) low offsets are special registers, higher ones general RAM.
// (RL9) every bank decodes special registers; mirrored copies share one register.
// (RL10) data file is reached directly or through the indirect pointer.
// (RL11) wrap is done by using only the low 11 counter bits.
`timescale 1ns/1ps
module mmbs_memory_map (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic pcAdvance,
	input wire logic pcJump,
	input wire logic [12:0] pcTarget,
	input wire logic intTake,
	output logic [12:0] pc,
	output logic [10:0] progAddr,
	output logic [13:0] progData,
	input wire logic progWrEn,
	input wire logic [10:0] progWrAddr,
	input wire logic [13:0] progWrData,
	input wire logic [6:0] dataOffset,
	input wire logic dataRdEn,
	input wire logic dataWrEn,
	input wire logic [7:0] dataWrData,
	output logic [7:0] dataRdData,
	output logic [1:0] bankSel,
	output logic [7:0] indirectPointer,
	output logic extSel,
	output logic [8:0] extAddr,
	input wire logic [7:0] extRdData
);
	// ****************************************
	// program counter and program store
	// ****************************************
	logic [12:0] pc_r;
	logic [12:0] pc_nxt;

	always_comb begin
		pc_nxt = pc_r;
		if (!rstn) begin
			pc_nxt = mmbs_pkg::RESET_VECTOR; // see RL3
		end else if (intTake) begin
			pc_nxt = mmbs_pkg::INT_VECTOR; // see RL4
		end else if (pcJump) begin
			pc_nxt = pcTarget;
		end else if (pcAdvance) begin
			pc_nxt = 13'(pc_r + 13'h0001); // see RL1
		end
	end

	always_ff @(posedge clk_sys) begin
		pc_r <= pc_nxt;
	end

	assign pc = pc_r;
	// upper bits are simply dropped, so 0800h..1FFFh alias onto the 2K store
	assign progAddr = pc_r[mmbs_pkg::PROG_ADDR_W-1:0]; // see RL2, see RL11

	// own read port, independent of the data file below
	mmbs_ram #(
		.WIDTH(mmbs_pkg::PROG_WORD_W),
		.DEPTH(mmbs_pkg::PROG_DEPTH),
		.AW(mmbs_pkg::PROG_ADDR_W)
	) u_prog (
		.clk_sys(clk_sys),
		.wrEn(progWrEn),
		.wrAddr(progWrAddr),
		.wrData(progWrData),
		.rdAddr(progAddr),
		.rdData(progData)
	); // see RL5

	// ****************************************
	// address formation
	// ****************************************
	logic [7:0] status_r;
	logic [7:0] status_nxt;
	logic [7:0] pointer_r;
	logic [7:0] pointer_nxt;
	logic [8:0] fileAddr;
	logic [6:0] effOff;
	logic isIndirect;

	assign bankSel = status_r[mmbs_pkg::STATUS_BSEL_HI:mmbs_pkg::STATUS_BSEL_LO];
	assign indirectPointer = pointer_r;
	assign isIndirect = (dataOffset == mmbs_pkg::OFF_INDIRECT);

	always_comb begin
		if (isIndirect) begin
			fileAddr = {status_r[mmbs_pkg::STATUS_IND_BANK], pointer_r}; // see RL10
		end else begin
			fileAddr = {bankSel, dataOffset}; // see RL6, see RL7
		end
	end

	assign effOff = fileAddr[mmbs_pkg::OFF_W-1:0];

	// ****************************************
	// decode
	// ****************************************
	// core registers mirrored in every bank decode to one flop each
	function automatic logic [1:0] coreHit(input logic [6:0] off);
		coreHit = {off == mmbs_pkg::OFF_POINTER, off == mmbs_pkg::OFF_STATUS};
	endfunction : coreHit

	// general RAM index: banks 0/2 share 96 bytes, banks 1/3 add 32 more,
	// 70h..7Fh is common to all banks; returns {hit, index}
	function automatic logic [7:0] ramMap(input logic [8:0] fa);
		logic [6:0] off;
		off = fa[6:0];
		ramMap = 8'h00;
		if (off < mmbs_pkg::GPR_BASE) begin
			ramMap = 8'h00;
		end else if (!fa[7] || off >= mmbs_pkg::SHARED_BASE) begin
			ramMap = {1'b1, 7'(off - mmbs_pkg::GPR_BASE)};
		end else if (off <= mmbs_pkg::ODD_GPR_LAST) begin
			ramMap = {1'b1, 7'(off - mmbs_pkg::GPR_BASE + mmbs_pkg::ODD_BANK_IDX_BASE)};
		end
	endfunction : ramMap

	logic [7:0] ramHit;
	logic [1:0] coreSel;
	logic sfrRegion;
	logic ramWe;
	logic [7:0] ramRdData;

	assign ramHit = ramMap(fileAddr);
	assign coreSel = coreHit(effOff);
	assign sfrRegion = (effOff < mmbs_pkg::GPR_BASE); // see RL8
	// an indirect access whose pointer names offset 0 touches nothing
	assign extSel = sfrRegion && (coreSel == 2'b00) && (effOff != mmbs_pkg::OFF_INDIRECT)
		&& (dataRdEn || dataWrEn); // see RL9
	assign extAddr = fileAddr;
	assign ramWe = dataWrEn && ramHit[7] && !sfrRegion; // see RL8

	mmbs_ram #(
		.WIDTH(mmbs_pkg::DATA_W),
		.DEPTH(mmbs_pkg::RAM_DEPTH),
		.AW(mmbs_pkg::RAM_IDX_W)
	) u_gpr (
		.clk_sys(clk_sys),
		.wrEn(ramWe),
		.wrAddr(ramHit[6:0]),
		.wrData(dataWrData),
		.rdAddr(ramHit[6:0]),
		.rdData(ramRdData)
	);

	// ****************************************
	// core registers and read path
	// ****************************************
	mmbs_pkg::mmbs_src_t src_r;
	mmbs_pkg::mmbs_src_t src_nxt;
	logic [7:0] coreRd_r;
	logic [7:0] coreRd_nxt;
	logic [7:0] extRd_r;
	logic [7:0] extRd_nxt;

	always_comb begin
		status_nxt = status_r;
		pointer_nxt = pointer_r;
		src_nxt = mmbs_pkg::MMBS_SRC_NONE;
		coreRd_nxt = 8'h00;
		extRd_nxt = extRd_r;
		if (!rstn) begin
			status_nxt = mmbs_pkg::STATUS_RESET;
			pointer_nxt = mmbs_pkg::POINTER_RESET;
			extRd_nxt = 8'h00;
		end else begin
			if (dataWrEn && coreSel[0]) begin
				status_nxt = dataWrData; // see RL9
			end
			if (dataWrEn && coreSel[1]) begin
				pointer_nxt = dataWrData; // see RL9
			end
			if (dataRdEn) begin
				if (coreSel[0]) begin
					src_nxt = mmbs_pkg::MMBS_SRC_CORE;
					coreRd_nxt = status_r;
				end else if (coreSel[1]) begin
					src_nxt = mmbs_pkg::MMBS_SRC_CORE;
					coreRd_nxt = pointer_r;
				end else if (extSel) begin
					src_nxt = mmbs_pkg::MMBS_SRC_EXT;
					extRd_nxt = extRdData;
				end else if (ramHit[7] && !sfrRegion) begin
					src_nxt = mmbs_pkg::MMBS_SRC_RAM;
				end
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		status_r <= status_nxt;
		pointer_r <= pointer_nxt;
		src_r <= src_nxt;
		coreRd_r <= coreRd_nxt;
		extRd_r <= extRd_nxt;
	end

	// unimplemented locations read as zero
	always_comb begin
		case (src_r)
			mmbs_pkg::MMBS_SRC_RAM: dataRdData = ramRdData;
			mmbs_pkg::MMBS_SRC_CORE: dataRdData = coreRd_r;
			mmbs_pkg::MMBS_SRC_EXT: dataRdData = extRd_r;
			default: dataRdData = 8'h00;
		endcase
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	sequence sIntTaken;
		intTake;
	endsequence
	// counter and fetch address both land on the edge after the take
	sequence sAtIntVector;
		pc == mmbs_pkg::INT_VECTOR && progAddr == 11'h004;
	endsequence
	sequence sStatusWrite;
		dataWrEn && !isIndirect && dataOffset == mmbs_pkg::OFF_STATUS;
	endsequence
	sequence sStatusRead;
		dataRdEn && !dataWrEn && coreSel[0];
	endsequence
	sequence sPlainStep;
		pcAdvance && !intTake && !pcJump;
	endsequence

	chk_pc_wraps_top: assert property ( // see RL1
		sPlainStep and pc == 13'h1FFF |=> pc == 13'h0000)
		else $error("pc did not wrap from 1FFFh to zero");
	chk_prog_wrap_low: assert property ( // see RL2
		sPlainStep and pc[10:0] == 11'h7FF |=> progAddr == 11'h000)
		else $error("program address did not wrap onto the 2K store");
	chk_prog_low_bits: assert property ( // see RL11
		pcJump && !intTake |=> progAddr == $past(pcTarget[10:0]))
		else $error("program address not the low 11 counter bits");
	chk_reset_vector: assert property ( // see RL3
		@(posedge clk_sys) disable iff (1'b0) !rstn |=> pc == 13'h0000)
		else $error("pc not at zero after reset");
	chk_int_vector: assert property ( // see RL4
		sIntTaken |=> sAtIntVector)
		else $error("interrupt did not vector to 0004h");
	chk_fetch_concurrent: assert property ( // see RL5
		sPlainStep and dataWrEn |=> pc == 13'($past(pc) + 13'h0001))
		else $error("data access stalled instruction fetch");
	chk_bank_direct: assert property ( // see RL6
		dataWrEn && !isIndirect |-> fileAddr[8:7] == status_r[6:5])
		else $error("direct access used the wrong bank");
	chk_bank_span: assert property ( // see RL7
		!isIndirect |-> fileAddr[6:0] == dataOffset)
		else $error("bank offset altered");
	chk_sfr_no_ram: assert property ( // see RL8
		dataWrEn && effOff < 7'h20 |-> !ramWe)
		else $error("special register offset wrote general RAM");
	chk_status_mirror: assert property ( // see RL9
		sStatusWrite |=> status_r == $past(dataWrData))
		else $error("mirrored status copies disagree");
	chk_status_readback: assert property ( // see RL9
		sStatusRead |=> dataRdData == $past(status_r))
		else $error("status read did not return the register");
	chk_bank_field: assert property ( // see RL6
		sStatusWrite |=> bankSel == $past(dataWrData[6:5]))
		else $error("bank select not taken from status bits 6 and 5");
	chk_indirect_addr: assert property ( // see RL10
		isIndirect |-> fileAddr == {status_r[7], pointer_r})
		else $error("indirect access ignored the pointer");
endmodule : mmbs_memory_map

// *** hw/mmbs_ram.sv ***
// mmbs_ram: simple one-write one-read memory with registered read data.
// assumes write and read ports may be used in the same cycle.
`timescale 1ns/1ps
module mmbs_ram #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 128,
	parameter int AW = 7
) (
	input wire logic clk_sys,
	input wire logic wrEn,
	input wire logic [AW-1:0] wrAddr,
	input wire logic [WIDTH-1:0] wrData,
	input wire logic [AW-1:0] rdAddr,
	output logic [WIDTH-1:0] rdData
);
	generate
		if (DEPTH > (1 << AW) || DEPTH < 1 || WIDTH < 1) begin : g_bad
			$error("mmbs_ram: depth does not fit address width");
		end
	endgenerate

	logic [WIDTH-1:0] mem [DEPTH];
	logic [WIDTH-1:0] rdData_r;

	// contents are not reset: storage, not control state
	always_ff @(posedge clk_sys) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
		rdData_r <= mem[rdAddr];
	end

	assign rdData = rdData_r;
endmodule : mmbs_ram

// *** include/mmbs_pkg.sv ***
// mmbs_pkg: constants for the program counter and banked data memory map.
// assumes a single 20 MHz core clock; no timing counts are needed here.
package mmbs_pkg;
	// ****************************************
	// program side
	// ****************************************
	localparam int PC_W = 13;
	localparam int PROG_ADDR_W = 11;
	localparam int PROG_WORD_W = 14;
	localparam int PROG_DEPTH = 2048;
	localparam logic [12:0] RESET_VECTOR = 13'h0000;
	localparam logic [12:0] INT_VECTOR = 13'h0004;

	// ****************************************
	// data side
	// ****************************************
	localparam int DATA_W = 8;
	localparam int OFF_W = 7;
	localparam int FILE_ADDR_W = 9;
	localparam int RAM_DEPTH = 128;
	localparam int RAM_IDX_W = 7;
	localparam logic [6:0] OFF_INDIRECT = 7'h00;
	localparam logic [6:0] OFF_STATUS = 7'h03;
	localparam logic [6:0] OFF_POINTER = 7'h04;
	localparam logic [6:0] GPR_BASE = 7'h20;
	localparam logic [6:0] ODD_GPR_LAST = 7'h3F;
	localparam logic [6:0] SHARED_BASE = 7'h70;
	localparam logic [6:0] ODD_BANK_IDX_BASE = 7'h60;
	localparam int STATUS_BSEL_LO = 5;
	localparam int STATUS_BSEL_HI = 6;
	localparam int STATUS_IND_BANK = 7;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] POINTER_RESET = 8'h00;

	typedef enum logic [1:0] {
		MMBS_SRC_NONE = 2'b00,
		MMBS_SRC_RAM = 2'b01,
		MMBS_SRC_CORE = 2'b10,
		MMBS_SRC_EXT = 2'b11
	} mmbs_src_t;
endpackage : mmbs_pkg

// *** tb/mmbs_memory_map_tb_top.sv ***
// mmbs_memory_map_tb_top: self-checking bench for the memory map block.
// assumes mmbs_pkg and the hw files are compiled first; bench acts as core.
`timescale 1ns/1ps
module mmbs_memory_map_tb_top;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic pcAdvance = 1'b0;
	logic pcJump = 1'b0;
	logic [12:0] pcTarget = 13'h0000;
	logic intTake = 1'b0;
	logic progWrEn = 1'b0;
	logic [10:0] progWrAddr = 11'h000;
	logic [13:0] progWrData = 14'h0000;
	logic [6:0] dataOffset = 7'h00;
	logic dataRdEn = 1'b0;
	logic dataWrEn = 1'b0;
	logic [7:0] dataWrData = 8'h00;
	logic [7:0] extRdData = 8'h00;
	logic [12:0] pc;
	logic [10:0] progAddr;
	logic [13:0] progData;
	logic [7:0] dataRdData;
	logic [1:0] bankSel;
	logic [7:0] indirectPointer;
	logic extSel;
	logic [8:0] extAddr;
	int miscompares = 0;
	int samplesChecked = 0;
	int cycleCount = 0;

	always #25 clk_sys = ~clk_sys;

	mmbs_memory_map i_mmbs_memory_map (.clk_sys(clk_sys), .rstn(rstn), .pcAdvance(pcAdvance),
		.pcJump(pcJump), .pcTarget(pcTarget), .intTake(intTake), .pc(pc),
		.progAddr(progAddr), .progData(progData), .progWrEn(progWrEn),
		.progWrAddr(progWrAddr), .progWrData(progWrData), .dataOffset(dataOffset),
		.dataRdEn(dataRdEn), .dataWrEn(dataWrEn), .dataWrData(dataWrData),
		.dataRdData(dataRdData), .bankSel(bankSel), .indirectPointer(indirectPointer),
		.extSel(extSel), .extAddr(extAddr), .extRdData(extRdData));

	// ****************************************
	// reporting and helpers
	// ****************************************
	task automatic final_report;
		if (miscompares == 0 && samplesChecked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : final_report

	// ceiling far above the roughly 85 cycles the scenarios need
	always @(posedge clk_sys) begin
		cycleCount++;
		if (cycleCount == 3000) begin
			miscompares++;
			final_report();
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		samplesChecked++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	// inputs always move 1 ns after the rising edge
	task automatic tick;
		@(posedge clk_sys);
		#1;
	endtask : tick

	task automatic wr(input logic [6:0] off, input logic [7:0] val);
		dataOffset = off;
		dataWrData = val;
		dataWrEn = 1'b1;
		tick();
		dataWrEn = 1'b0;
		// idle edge, so back-to-back calls never toggle the strobe in one step
		tick();
	endtask : wr

	task automatic rdchk(input logic [6:0] off, input logic [7:0] exp, input string what);
		dataOffset = off;
		dataRdEn = 1'b1;
		tick();
		dataRdEn = 1'b0;
		check(16'(dataRdData), 16'(exp), what);
		tick();
	endtask : rdchk

	task automatic set_bank(input logic [1:0] b);
		wr(mmbs_pkg::OFF_STATUS, {1'b0, b, 5'h00});
	endtask : set_bank

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_program;
		progWrEn = 1'b1;
		progWrAddr = 11'h004;
		progWrData = 14'h1A2B;
		tick();
		progWrAddr = 11'h005;
		progWrData = 14'h2C3D;
		tick();
		progWrEn = 1'b0;
		// interrupt wins over a jump in the same cycle
		intTake = 1'b1;
		pcJump = 1'b1;
		pcTarget = 13'h0123;
		tick();
		intTake = 1'b0;
		pcJump = 1'b0;
		check(16'(pc), 16'h0004, "int vector");
		tick();
		check(16'(progData), 16'h1A2B, "word at 4");
		pcJump = 1'b1;
		pcTarget = 13'h1805;
		tick();
		pcJump = 1'b0;
		check(16'(pc), 16'h1805, "pc high bits");
		check(16'(progAddr), 16'h0005, "wrapped fetch");
		tick();
		check(16'(progData), 16'h2C3D, "wrapped word");
		pcJump = 1'b1;
		pcTarget = 13'h1FFF;
		tick();
		pcJump = 1'b0;
		// step and data write share one edge
		pcAdvance = 1'b1;
		dataOffset = 7'h20;
		dataWrData = 8'h5A;
		dataWrEn = 1'b1;
		tick();
		pcAdvance = 1'b0;
		dataWrEn = 1'b0;
		check(16'(pc), 16'h0000, "13-bit roll");
		rdchk(7'h20, 8'h5A, "concurrent write");
	endtask : t_program

	task automatic t_banks;
		for (int b = 0; b < 4; b++) begin
			set_bank(2'(b));
			check(16'(bankSel), 16'(b), "bank select");
			wr(7'h20, 8'(8'h10 + b));
		end
		// banks 0/2 and banks 1/3 pair up on general RAM, last write wins
		for (int b = 0; b < 4; b++) begin
			set_bank(2'(b));
			rdchk(7'h20, (b % 2 == 1) ? 8'h13 : 8'h12, "bank ram");
		end
		rdchk(mmbs_pkg::OFF_STATUS, 8'h60, "status mirror");
		set_bank(2'b01);
		wr(7'h7F, 8'hC3);
		wr(7'h40, 8'hEE);
		rdchk(7'h40, 8'h00, "unimplemented gap");
		set_bank(2'b00);
		rdchk(7'h7F, 8'hC3, "top offset shared");
	endtask : t_banks

	task automatic t_indirect;
		wr(7'h25, 8'hA5);
		wr(mmbs_pkg::OFF_POINTER, 8'h25);
		check(16'(indirectPointer), 16'h0025, "pointer");
		// bank 3 so a direct read of 25h would hit a different RAM byte
		set_bank(2'b11);
		dataOffset = 7'h05;
		dataRdEn = 1'b1;
		extRdData = 8'h9C;
		#1;
		check(16'(extSel), 16'h0001, "ext select");
		check(16'(extAddr), 16'h0185, "ext address");
		tick();
		dataRdEn = 1'b0;
		extRdData = 8'h00;
		check(16'(dataRdData), 16'h009C, "ext data");
		tick();
		// indirect ignores the direct bank bits
		rdchk(mmbs_pkg::OFF_INDIRECT, 8'hA5, "indirect read");
		wr(mmbs_pkg::OFF_INDIRECT, 8'h77);
		set_bank(2'b00);
		rdchk(7'h25, 8'h77, "indirect write");
	endtask : t_indirect

	task automatic t_reset;
		wr(mmbs_pkg::OFF_STATUS, 8'h40);
		rstn = 1'b0;
		tick();
		rstn = 1'b1;
		check(16'(pc), 16'h0000, "reset pc");
		check(16'(bankSel), 16'h0000, "reset bank");
		check(16'(indirectPointer), 16'h0000, "reset pointer");
	endtask : t_reset

	initial begin
		repeat (8) tick();
		rstn = 1'b1;
		check(16'(pc), 16'h0000, "first reset pc");
		t_program();
		t_banks();
		t_indirect();
		pcJump = 1'b1;
		pcTarget = 13'h0ABC;
		tick();
		pcJump = 1'b0;
		t_reset();
		final_report();
	end
endmodule : mmbs_memory_map_tb_top
